/* File: dv/test_autoneg_next_page_and_expansion_status.sv */
`timescale 1ns/1ns
module test_autoneg_next_page_and_expansion_status;
  import anx_pkg::*;
  logic mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, pv, msg, cf, tog;
  logic pdet, lpnp, lpan;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [10:0] code;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  localparam logic [7:0] NA = {PARTNER_NP_IDX, 2'b00};
  localparam logic [7:0] EA = {AUTONEG_EXP_IDX, 2'b00};
  localparam logic [7:0] SA = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [7:0] CA = {IRQ_CLEAR_IDX, 2'b00};
  localparam logic [7:0] NEA = {IRQ_ENABLE_IDX, 2'b00};
  localparam logic [1:0] OK = RESP_OKAY;

  anx_status_regs u_anx_status_regs (
    .mclk(mclk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .page_valid(pv), .rx_message_page(msg), .rx_comply(cf),
    .rx_toggle(tog), .rx_code(code), .parallel_detect_fault(pdet),
    .partner_next_page_capable(lpnp), .partner_autoneg_capable(lpan),
    .irq(irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Handshakes sampled at the falling edge, where nothing is moving
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic at;
    logic wt;
    logic bt;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    while (!bt)
    begin
      @(negedge mclk);
      at = awvalid & awready;
      wt = wvalid & wready;
      bt = bvalid;
      if (bt)
        chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge mclk);
      if (at)
        awvalid <= 1'b0;
      if (wt)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    logic at;
    logic rt;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rt = 1'b0;
    while (!rt)
    begin
      @(negedge mclk);
      at = arvalid & arready;
      rt = rvalid;
      if (rt)
      begin
        chk($sformatf("rdata at %h", a), rdata, ed);
        chk($sformatf("rresp at %h", a), {30'h0, rresp}, {30'h0, er});
      end
      @(posedge mclk);
      if (at)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd

  task automatic page(logic m, logic c, logic t, logic [10:0] k);
    @(posedge mclk);
    pv <= 1'b1;
    msg <= m;
    cf <= c;
    tog <= t;
    code <= k;
    @(posedge mclk);
    pv <= 1'b0;
  endtask : page

  task automatic irqc(logic e);
    @(negedge mclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : irqc

  task automatic lines(logic [2:0] v);
    @(posedge mclk);
    {pdet, lpnp, lpan} <= v;
  endtask : lines

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(NA, 32'h0, OK);
    rd(EA, 32'h4, OK);
    rd(NEA, 32'h0, OK);
    rd(SA, 32'h0, OK);
    irqc(1'b0);
  endtask : t_reset

  task automatic t_pages();
    page(1'b1, 1'b1, 1'b0, 11'h5a5);
    rd(NA, 32'h35a5, OK);
    rd(EA, 32'h6, OK);
    rd(EA, 32'h4, OK);
    page(1'b0, 1'b0, 1'b1, 11'h7ff);
    rd(NA, 32'h0fff, OK);
    rd(EA, 32'h6, OK);
  endtask : t_pages

  task automatic t_live();
    lines(3'b100);
    rd(EA, 32'h14, OK);
    lines(3'b010);
    rd(EA, 32'hc, OK);
    lines(3'b001);
    rd(EA, 32'h5, OK);
    lines(3'b000);
    rd(EA, 32'h4, OK);
  endtask : t_live

  task automatic t_regs();
    wr(EA, 32'hffffffff, OK);
    rd(EA, 32'h4, OK);
    wr(NA, 32'hffffffff, OK);
    rd(NA, 32'h0fff, OK);
    wr(8'h3c, 32'h1, RESP_SLVERR);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    rd(CA, 32'h0, OK);
    // Enable write with its low lane off must leave enables alone
    @(posedge mclk);
    wstrb <= 4'he;
    wr(NEA, 32'h3, OK);
    rd(NEA, 32'h0, OK);
    wstrb <= 4'hf;
  endtask : t_regs

  task automatic t_irq();
    rd(SA, 32'h3, OK);
    wr(CA, 32'h3, OK);
    rd(SA, 32'h0, OK);
    wr(NEA, 32'h3, OK);
    rd(NEA, 32'h3, OK);
    irqc(1'b0);
    page(1'b1, 1'b0, 1'b1, 11'h001);
    irqc(1'b1);
    rd(SA, 32'h1, OK);
    rd(NA, 32'h2801, OK);
    wr(NEA, 32'h0, OK);
    irqc(1'b0);
    wr(NEA, 32'h1, OK);
    irqc(1'b1);
    wr(CA, 32'h1, OK);
    irqc(1'b0);
    rd(SA, 32'h0, OK);
  endtask : t_irq

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic stop_test();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Whole run needs under 150 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {pv, msg, cf, tog, pdet, lpnp, lpan} = 7'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    code = 11'h0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_pages();
    t_live();
    t_regs();
    t_irq();
    stop_test();
  end
endmodule : test_autoneg_next_page_and_expansion_status

/* File: verilog/anx_pkg.sv */
package anx_pkg;
  // ----------------------------------------
  // Register indices, byte address is 4x
  // ----------------------------------------
  localparam logic [5:0] PARTNER_NP_IDX = 6'h05;
  localparam logic [5:0] AUTONEG_EXP_IDX = 6'h06;
  localparam logic [5:0] IRQ_STATUS_IDX = 6'h10;
  localparam logic [5:0] IRQ_CLEAR_IDX = 6'h11;
  localparam logic [5:0] IRQ_ENABLE_IDX = 6'h12;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NP_MSG_BIT = 13;
  localparam int NP_ACK_BIT = 12;
  localparam int NP_TOG_BIT = 11;
  localparam int NP_CODE_W = 11;
  localparam int EXP_FAULT_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_NP_BIT = 2;
  localparam int EXP_PRX_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;
  localparam int IRQ_PAGE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_W = 2;
  // ----------------------------------------
  // Reset values and responses
  // ----------------------------------------
  localparam logic LOCAL_NP_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : anx_pkg

/* File: verilog/anx_status_regs.sv */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// - Bit 13 shows received message page flag
// - Bit 12 shows partner can comply
// - Bit 11 shows received toggle status
// - Bits 10:0 show received code field
// - Expansion bits 15:5 read zero, ignore writes
// - Expansion bit 4 shows parallel detect fault
// - Expansion bit 3 shows partner next page
// - Expansion bit 2 reads one, local next page
// - Expansion bit 1 sets on page, clears on read
// - Expansion bit 0 shows partner autoneg ability
module anx_status_regs
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [anx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [anx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic page_valid,
  input wire logic rx_message_page,
  input wire logic rx_comply,
  input wire logic rx_toggle,
  input wire logic [anx_pkg::NP_CODE_W-1:0] rx_code,
  input wire logic parallel_detect_fault,
  input wire logic partner_next_page_capable,
  input wire logic partner_autoneg_capable,
  output logic irq
);
  import anx_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic message_page_flag, next_message_page_flag;
  logic partner_comply_flag, next_partner_comply_flag;
  logic toggle_flag, next_toggle_flag;
  logic [NP_CODE_W-1:0] code_field, next_code_field;
  logic page_received, next_page_received;
  logic local_next_page_capable, next_local_next_page_capable;
  logic fault_last, next_fault_last;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_enable, next_irq_enable;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [5:0] aw_idx, next_aw_idx;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic bvalid_q, next_bvalid_q;
  logic [1:0] bresp_q, next_bresp_q;
  logic rvalid_q, next_rvalid_q;
  logic [1:0] rresp_q, next_rresp_q;
  logic [31:0] rdata_q, next_rdata_q;
  logic rd_take, wr_fire, exp_read;
  logic [5:0] ar_idx;
  logic [15:0] np_word, exp_word;
  logic [IRQ_W-1:0] events;

  assign ar_idx = s_axi_araddr[IDX_LSB+5:IDX_LSB];
  assign s_axi_arready = !rvalid_q;
  assign s_axi_awready = !aw_held && !bvalid_q;
  assign s_axi_wready = !w_held && !bvalid_q;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign exp_read = rd_take && (ar_idx == AUTONEG_EXP_IDX);
  assign wr_fire = aw_held && w_held && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = |(irq_status & irq_enable);

  always_comb
  begin
    np_word = 16'h0000;
    np_word[NP_MSG_BIT] = message_page_flag;
    np_word[NP_ACK_BIT] = partner_comply_flag;
    np_word[NP_TOG_BIT] = toggle_flag;
    np_word[NP_CODE_W-1:0] = code_field;
    exp_word = 16'h0000;
    exp_word[EXP_FAULT_BIT] = parallel_detect_fault;
    exp_word[EXP_LPNP_BIT] = partner_next_page_capable;
    exp_word[EXP_NP_BIT] = local_next_page_capable;
    exp_word[EXP_PRX_BIT] = page_received;
    exp_word[EXP_LPAN_BIT] = partner_autoneg_capable;
  end

  // ----------------------------------------
  // Next page capture and events
  // ----------------------------------------
  always_comb
  begin
    next_message_page_flag = message_page_flag;
    next_partner_comply_flag = partner_comply_flag;
    next_toggle_flag = toggle_flag;
    next_code_field = code_field;
    next_local_next_page_capable = local_next_page_capable;
    next_fault_last = parallel_detect_fault;
    if (page_valid)
    begin
      next_message_page_flag = rx_message_page;
      next_partner_comply_flag = rx_comply;
      next_toggle_flag = rx_toggle;
      next_code_field = rx_code;
    end
    // Set wins over clear-on-read, so no page is lost
    next_page_received = page_received;
    if (exp_read)
      next_page_received = 1'b0;
    if (page_valid)
      next_page_received = 1'b1;
    events = '0;
    events[IRQ_PAGE_BIT] = page_valid;
    events[IRQ_FAULT_BIT] = parallel_detect_fault && !fault_last;
    next_irq_status = irq_status;
    next_irq_enable = irq_enable;
    if (wr_fire && wstrb_q[0] && aw_idx == IRQ_CLEAR_IDX)
      next_irq_status = irq_status & ~wdata_q[IRQ_W-1:0];
    if (wr_fire && wstrb_q[0] && aw_idx == IRQ_ENABLE_IDX)
      next_irq_enable = wdata_q[IRQ_W-1:0];
    next_irq_status = next_irq_status | events;
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid_q = bvalid_q;
    next_bresp_q = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr[IDX_LSB+5:IDX_LSB];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid_q = 1'b1;
      // Status registers accept writes silently and keep their value
      case (aw_idx)
        PARTNER_NP_IDX, AUTONEG_EXP_IDX, IRQ_STATUS_IDX,
        IRQ_CLEAR_IDX, IRQ_ENABLE_IDX: next_bresp_q = RESP_OKAY;
        default: next_bresp_q = RESP_SLVERR;
      endcase
    end
    else if (bvalid_q && s_axi_bready)
      next_bvalid_q = 1'b0;
    next_rvalid_q = rvalid_q;
    next_rresp_q = rresp_q;
    next_rdata_q = rdata_q;
    if (rd_take)
    begin
      next_rvalid_q = 1'b1;
      next_rresp_q = RESP_OKAY;
      case (ar_idx)
        PARTNER_NP_IDX: next_rdata_q = {16'h0000, np_word};
        AUTONEG_EXP_IDX: next_rdata_q = {16'h0000, exp_word};
        IRQ_STATUS_IDX: next_rdata_q = {30'h0, irq_status};
        IRQ_ENABLE_IDX: next_rdata_q = {30'h0, irq_enable};
        IRQ_CLEAR_IDX: next_rdata_q = 32'h0000_0000;
        default:
        begin
          next_rdata_q = 32'h0000_0000;
          next_rresp_q = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      next_rvalid_q = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      message_page_flag <= 1'b0;
      partner_comply_flag <= 1'b0;
      toggle_flag <= 1'b0;
      code_field <= '0;
      page_received <= 1'b0;
      local_next_page_capable <= LOCAL_NP_RESET;
      fault_last <= 1'b0;
      irq_status <= '0;
      irq_enable <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      message_page_flag <= next_message_page_flag;
      partner_comply_flag <= next_partner_comply_flag;
      toggle_flag <= next_toggle_flag;
      code_field <= next_code_field;
      page_received <= next_page_received;
      local_next_page_capable <= next_local_next_page_capable;
      fault_last <= next_fault_last;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid_q <= next_bvalid_q;
      bresp_q <= next_bresp_q;
      rvalid_q <= next_rvalid_q;
      rresp_q <= next_rresp_q;
      rdata_q <= next_rdata_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_b);

  msg_capture_a: assert property (page_valid |=>
    message_page_flag == $past(rx_message_page))
    else $error("message page flag not loaded");
  comply_capture_a: assert property (page_valid |=>
    partner_comply_flag == $past(rx_comply))
    else $error("comply flag not loaded");
  toggle_capture_a: assert property (page_valid |=>
    toggle_flag == $past(rx_toggle))
    else $error("toggle flag not loaded");
  code_read_a: assert property (
    rd_take && ar_idx == PARTNER_NP_IDX |=>
    s_axi_rdata[NP_CODE_W-1:0] == $past(code_field)
    && s_axi_rdata[31:16] == 16'h0000)
    else $error("code field read wrong");
  exp_zero_a: assert property (exp_read |=>
    s_axi_rvalid && s_axi_rdata[31:5] == 27'h0)
    else $error("expansion reserved bits nonzero");
  fault_read_a: assert property (exp_read |=>
    s_axi_rdata[EXP_FAULT_BIT] == $past(parallel_detect_fault))
    else $error("parallel detect fault read wrong");
  lpnp_read_a: assert property (exp_read |=>
    s_axi_rdata[EXP_LPNP_BIT] == $past(partner_next_page_capable))
    else $error("partner next page read wrong");
  local_np_a: assert property (exp_read |=>
    s_axi_rdata[EXP_NP_BIT])
    else $error("local next page bit not one");
  page_clear_a: assert property (
    exp_read && !page_valid |=> !page_received ##1 1'b1)
    else $error("page flag not cleared by read");
  page_set_a: assert property (page_valid |=>
    page_received && code_field == $past(rx_code))
    else $error("page flag or code not loaded together");
  lpan_read_a: assert property (exp_read |=>
    s_axi_rdata[EXP_LPAN_BIT] == $past(partner_autoneg_capable))
    else $error("partner autoneg read wrong");
endmodule : anx_status_regs
